/* hw/dsp_sram_port.sv */
`timescale 1ns/1ns
module dsp_sram_port
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // device clock pins, sampled
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic c_clk,
    input wire logic c_clk_n,
    input wire logic single_clock_mode,
    // command and write data
    input wire dsp_pkg::dsp_cmd_t cmd,
    input wire dsp_pkg::dsp_wdata_t wdata,
    // read data
    output logic [dsp_pkg::DATA_W-1:0] q_o,
    output logic q_oe
);

    // ----------------------------------------
    // edges and storage
    // ----------------------------------------
    logic [dsp_pkg::CLK_N-1:0] rise;
    logic out_pos;
    logic out_neg;
    logic start_rd;
    logic start_wr;
    logic mem_we;
    logic [dsp_pkg::DATA_W-1:0] mem_lo [dsp_pkg::DEPTH];
    logic [dsp_pkg::DATA_W-1:0] mem_hi [dsp_pkg::DEPTH];
    logic [dsp_pkg::DATA_W-1:0] old_lo;
    logic [dsp_pkg::DATA_W-1:0] old_hi;
    logic [dsp_pkg::DATA_W-1:0] new_lo;
    logic [dsp_pkg::DATA_W-1:0] new_hi;
    logic [dsp_pkg::DATA_W-1:0] rd_lo;
    logic [dsp_pkg::DATA_W-1:0] rd_hi;
    dsp_pkg::dsp_state_t st_q;
    dsp_pkg::dsp_state_t st_d;

    dsp_edge_det u_edge
    (
        .core_clk(core_clk),
        .nrst(nrst),
        .pins({c_clk_n, c_clk, k_clk_n, k_clk}),
        .rise(rise)
    );

    // output clocks fall back to input clocks in single clock mode
    assign out_pos = single_clock_mode ? rise[dsp_pkg::CLK_K] : rise[dsp_pkg::CLK_C];
    assign out_neg = single_clock_mode ? rise[dsp_pkg::CLK_KN] : rise[dsp_pkg::CLK_CN];

    // accesses start only at K rise with load low
    assign start_rd = rise[dsp_pkg::CLK_K] && cmd.cycle_define_n == dsp_pkg::LOAD_ACTIVE
        && cmd.rw_sel == dsp_pkg::RW_READ;
    assign start_wr = rise[dsp_pkg::CLK_K] && cmd.cycle_define_n == dsp_pkg::LOAD_ACTIVE
        && cmd.rw_sel != dsp_pkg::RW_READ;

    // write commits at the K# rise carrying the second word
    assign mem_we = st_q.wr_pend && rise[dsp_pkg::CLK_KN];
    assign old_lo = mem_lo[st_q.wr_addr];
    assign old_hi = mem_hi[st_q.wr_addr];
    assign rd_lo = mem_lo[st_q.rd_addr];
    assign rd_hi = mem_hi[st_q.rd_addr];

    // ----------------------------------------
    // per-lane merge
    // ----------------------------------------
    for (genvar g = 0; g < dsp_pkg::LANES; g++)
    begin : g_lane
        assign new_lo[g*dsp_pkg::LANE_W +: dsp_pkg::LANE_W] = st_q.wr_s0[g]
            ? old_lo[g*dsp_pkg::LANE_W +: dsp_pkg::LANE_W]
            : st_q.wr_d0[g*dsp_pkg::LANE_W +: dsp_pkg::LANE_W];
        assign new_hi[g*dsp_pkg::LANE_W +: dsp_pkg::LANE_W] = wdata.lane_write_select_n[g]
            ? old_hi[g*dsp_pkg::LANE_W +: dsp_pkg::LANE_W]
            : wdata.data[g*dsp_pkg::LANE_W +: dsp_pkg::LANE_W];
    end

    always_ff @(posedge core_clk)
    begin
        if (mem_we)
        begin
            mem_lo[st_q.wr_addr] <= new_lo;
            mem_hi[st_q.wr_addr] <= new_hi;
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        st_d = st_q;
        // launch first word or release the bus
        if (out_pos)
        begin
            if (st_q.rd_pend)
            begin
                st_d.q = rd_lo;
                st_d.rd_w1 = rd_hi;
                st_d.q_oe = 1'b1;
                st_d.phase = dsp_pkg::OUT_W0;
                st_d.rd_pend = 1'b0;
            end
            else
            begin
                st_d.q_oe = 1'b0;
                st_d.phase = dsp_pkg::OUT_IDLE;
            end
        end
        else if (out_neg)
        begin
            case (st_q.phase)
                dsp_pkg::OUT_W0:
                begin
                    st_d.q = st_q.rd_w1;
                    st_d.phase = dsp_pkg::OUT_W1;
                end
                dsp_pkg::OUT_IDLE, dsp_pkg::OUT_W1:
                begin
                    st_d.phase = st_q.phase;
                end
                default:
                begin
                    st_d.phase = dsp_pkg::OUT_IDLE;
                end
            endcase
        end
        // one address bus, routed by access type; ignored when not loaded
        if (start_rd)
        begin
            st_d.rd_pend = 1'b1;
            st_d.rd_addr = cmd.addr;
        end
        if (mem_we)
        begin
            st_d.wr_pend = 1'b0;
        end
        if (start_wr)
        begin
            st_d.wr_pend = 1'b1;
            st_d.wr_addr = cmd.addr;
            st_d.wr_d0 = wdata.data;
            st_d.wr_s0 = wdata.lane_write_select_n;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            st_q.phase <= dsp_pkg::OUT_IDLE;
            st_q.rd_pend <= 1'b0;
            st_q.rd_addr <= dsp_pkg::ADDR_RST;
            st_q.rd_w1 <= dsp_pkg::DATA_RST;
            st_q.wr_pend <= 1'b0;
            st_q.wr_addr <= dsp_pkg::ADDR_RST;
            st_q.wr_d0 <= dsp_pkg::DATA_RST;
            st_q.wr_s0 <= dsp_pkg::LANE_RST;
            st_q.q <= dsp_pkg::DATA_RST;
            st_q.q_oe <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign q_o = st_q.q;
    assign q_oe = st_q.q_oe;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    read_addr_cap_a: assert property (start_rd |=> st_q.rd_pend && st_q.rd_addr == $past(cmd.addr))
        else $error("read address not captured");
    write_type_a: assert property (start_wr |=> st_q.wr_pend && st_q.wr_addr == $past(cmd.addr))
        else $error("write access not loaded");
    addr_ignored_a: assert property (cmd.cycle_define_n && !st_q.rd_pend |=> !st_q.rd_pend)
        else $error("read loaded without load low");
    k_edge_only_a: assert property (!rise[dsp_pkg::CLK_K] && !st_q.wr_pend |=> !st_q.wr_pend)
        else $error("write started off K rise");
    first_word_a: assert property (out_pos && st_q.rd_pend |=> q_oe && q_o == $past(rd_lo))
        else $error("first read word wrong");
    second_word_a: assert property (!out_pos && out_neg && st_q.phase == dsp_pkg::OUT_W0
        |=> q_oe && q_o == $past(st_q.rd_w1))
        else $error("second read word wrong");
    bus_release_a: assert property (out_pos && !st_q.rd_pend |=> !q_oe)
        else $error("outputs not released");
    single_mode_a: assert property (single_clock_mode && !rise[dsp_pkg::CLK_K]
        && !rise[dsp_pkg::CLK_KN] |=> $stable(q_o) && $stable(q_oe))
        else $error("output moved off K edges");
    write_commit_a: assert property (mem_we && !start_wr |=> !st_q.wr_pend)
        else $error("write not committed");
    lane_keep_a: assert property (mem_we && wdata.lane_write_select_n[0]
        |=> mem_hi[$past(st_q.wr_addr)][dsp_pkg::LANE_W-1:0] == $past(old_hi[dsp_pkg::LANE_W-1:0]))
        else $error("deselected lane changed");
    lane_write_a: assert property (mem_we && !st_q.wr_s0[0]
        |=> mem_lo[$past(st_q.wr_addr)][dsp_pkg::LANE_W-1:0] == $past(st_q.wr_d0[dsp_pkg::LANE_W-1:0]))
        else $error("selected lane not written");

endmodule

/* hw/dsp_pkg.sv */
package dsp_pkg;

    // ----------------------------------------
    // widths per variant
    // ----------------------------------------
    localparam int ADDR_W_X8 = 22;
    localparam int ADDR_W_X9 = 22;
    localparam int ADDR_W_X18 = 21;
    localparam int ADDR_W_X36 = 20;

    // this build is the thirty-six-bit variant
    localparam int DATA_W = 36;
    localparam int LANE_W = 9;
    localparam int LANES = 4;
    localparam int ADDR_W = ADDR_W_X36;
    localparam int DEPTH = 1 << ADDR_W;

    // ----------------------------------------
    // clock pin positions in the edge vector
    // ----------------------------------------
    localparam int CLK_N = 4;
    localparam int CLK_K = 0;
    localparam int CLK_KN = 1;
    localparam int CLK_C = 2;
    localparam int CLK_CN = 3;

    // ----------------------------------------
    // reset values and encodings
    // ----------------------------------------
    localparam logic [CLK_N-1:0] EDGE_RST = 4'h0;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 20'h0_0000;
    localparam logic [LANES-1:0] LANE_RST = 4'hF;
    localparam logic RW_READ = 1'b1;
    localparam logic LOAD_ACTIVE = 1'b0;

    typedef enum logic [1:0] {
        OUT_IDLE,
        OUT_W0,
        OUT_W1
    } dsp_phase_t;

    typedef struct packed {
        logic cycle_define_n;
        logic rw_sel;
        logic [ADDR_W-1:0] addr;
    } dsp_cmd_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] lane_write_select_n;
    } dsp_wdata_t;

    typedef struct packed {
        dsp_phase_t phase;
        logic rd_pend;
        logic [ADDR_W-1:0] rd_addr;
        logic [DATA_W-1:0] rd_w1;
        logic wr_pend;
        logic [ADDR_W-1:0] wr_addr;
        logic [DATA_W-1:0] wr_d0;
        logic [LANES-1:0] wr_s0;
        logic [DATA_W-1:0] q;
        logic q_oe;
    } dsp_state_t;

    typedef struct packed {
        logic [CLK_N-1:0] prev;
    } dsp_edge_state_t;

endpackage

/* hw/dsp_edge_det.sv */
`timescale 1ns/1ns
module dsp_edge_det
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // sampled clock pins
    input wire logic [dsp_pkg::CLK_N-1:0] pins,
    // one-cycle rise pulses
    output logic [dsp_pkg::CLK_N-1:0] rise
);

    dsp_pkg::dsp_edge_state_t st_q;
    dsp_pkg::dsp_edge_state_t st_d;

    always_comb
    begin
        st_d.prev = pins;
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            st_q.prev <= dsp_pkg::EDGE_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign rise = pins & ~st_q.prev;

endmodule

/* test/dsp_ctrl_model.sv */
`timescale 1ns/1ns
module dsp_ctrl_model
(
    // clock
    input wire logic core_clk,
    // device pins
    output logic k_clk,
    output logic k_clk_n,
    output logic c_clk,
    output logic c_clk_n,
    output dsp_pkg::dsp_cmd_t cmd,
    output dsp_pkg::dsp_wdata_t wdata
);
    // ----------------------------------------
    // pin clocks, c lags k by a quarter period
    // ----------------------------------------
    logic [2:0] ph = 3'h0;
    logic [2:0] cph;
    always @(posedge core_clk) ph <= ph + 3'h1;
    assign cph = ph - 3'h2;
    assign k_clk = ~ph[2];
    assign k_clk_n = ph[2];
    assign c_clk = ~cph[2];
    assign c_clk_n = cph[2];
    initial cmd = '{1'b1, 1'b0, 20'h0_0000};
    initial wdata = '{36'h0_0000_0000, 4'hF};

    // ----------------------------------------
    // one command; load released high, other pins show inverse
    // ----------------------------------------
    task automatic issue(input logic load_n, input logic rw, input logic [19:0] a, input logic [35:0] w0,
        input logic [3:0] s0, input logic [35:0] w1, input logic [3:0] s1);
        @(posedge core_clk iff ph == 3'h7);
        cmd <= '{load_n, rw, a};
        wdata <= '{w0, s0};
        @(posedge core_clk);
        cmd <= '{1'b1, ~rw, ~a};
        wdata <= '{~w0, ~s0};
        if (!rw)
        begin
            @(posedge core_clk iff ph == 3'h3);
            wdata <= '{w1, s1};
            @(posedge core_clk);
            wdata <= '{~w1, ~s1};
        end
    endtask
endmodule

/* test/dsp_sram_port_test.sv */
`timescale 1ns/1ns
module dsp_sram_port_test;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic single_clock_mode = 1'b0;
    logic k_clk, k_clk_n, c_clk, c_clk_n, q_oe;
    logic [35:0] q_o;
    dsp_pkg::dsp_cmd_t cmd;
    dsp_pkg::dsp_wdata_t wdata;
    int n_errors = 0;
    int num_checks = 0;
    localparam logic [35:0] W0 = 36'h1_2345_6789;
    localparam logic [35:0] W1 = 36'hF_EDCB_A987;
    localparam logic [35:0] W2 = 36'h3_C3C3_C3C3;
    localparam logic [35:0] W3 = 36'hC_3C3C_3C3C;

    always #4 core_clk = ~core_clk;

    dsp_ctrl_model u_ctl (.core_clk(core_clk), .k_clk(k_clk), .k_clk_n(k_clk_n), .c_clk(c_clk),
        .c_clk_n(c_clk_n), .cmd(cmd), .wdata(wdata));
    dsp_sram_port u_dut (.core_clk(core_clk), .nrst(nrst), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .c_clk(c_clk), .c_clk_n(c_clk_n), .single_clock_mode(single_clock_mode), .cmd(cmd),
        .wdata(wdata), .q_o(q_o), .q_oe(q_oe));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic cmp(input logic [36:0] got, input logic [36:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %0t: %s", $time, what);
        end
    endtask

    function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] nw, input logic [3:0] sel_n);
        for (int i = 0; i < 4; i++)
            if (!sel_n[i])
                old[9*i +: 9] = nw[9*i +: 9];
        return old;
    endfunction

    task automatic read_back(input logic [19:0] a, input logic [35:0] lo, input logic [35:0] hi);
        int n;
        u_ctl.issue(1'b0, 1'b1, a, 36'h0_0000_0000, 4'hF, 36'h0_0000_0000, 4'hF);
        n = 0;
        while (q_oe !== 1'b1 && n < 40)
        begin
            @(negedge core_clk);
            n++;
        end
        cmp({q_oe, q_o}, {1'b1, lo}, "first read word");
        repeat (4) @(negedge core_clk);
        cmp({q_oe, q_o}, {1'b1, hi}, "second read word");
        repeat (4) @(negedge core_clk);
        cmp({36'h0, q_oe}, 37'h0, "outputs still driven");
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_write_read;
        u_ctl.issue(1'b0, 1'b0, 20'hF_FFFF, W0, 4'h0, W1, 4'h0);
        u_ctl.issue(1'b0, 1'b0, 20'h0_0000, W2, 4'h0, W3, 4'h0);
        @(negedge core_clk);
        cmp({36'h0, q_oe}, 37'h0, "driven during writes");
        read_back(20'hF_FFFF, W0, W1);
        read_back(20'h0_0000, W2, W3);
        $display("t_write_read done");
    endtask

    task automatic t_lanes;
        u_ctl.issue(1'b0, 1'b0, 20'h0_0000, 36'hA_AAAA_AAAA, 4'hA, 36'h5_5555_5555, 4'h5);
        read_back(20'h0_0000, merge(W2, 36'hA_AAAA_AAAA, 4'hA), merge(W3, 36'h5_5555_5555, 4'h5));
        $display("t_lanes done");
    endtask

    task automatic t_ignored;
        u_ctl.issue(1'b1, 1'b0, 20'hF_FFFF, 36'h0_0000_0000, 4'h0, 36'h0_0000_0000, 4'h0);
        u_ctl.issue(1'b1, 1'b1, 20'hF_FFFF, 36'h0_0000_0000, 4'h0, 36'h0_0000_0000, 4'h0);
        // a wrongly taken read would be driving here
        repeat (4) @(negedge core_clk);
        cmp({36'h0, q_oe}, 37'h0, "read without load");
        read_back(20'hF_FFFF, W0, W1);
        $display("t_ignored done");
    endtask

    task automatic t_single;
        @(posedge core_clk);
        single_clock_mode <= 1'b1;
        read_back(20'h0_0000, merge(W2, 36'hA_AAAA_AAAA, 4'hA), merge(W3, 36'h5_5555_5555, 4'h5));
        @(posedge core_clk);
        single_clock_mode <= 1'b0;
        $display("t_single done");
    endtask

    task give_verdict;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        t_write_read();
        t_lanes();
        t_ignored();
        t_single();
        give_verdict();
    end

    initial
    begin
        #20000;
        n_errors++;
        give_verdict();
    end
endmodule
